// [common/tcdio_pkg.sv]
// Package of register map, field layout and constants for the timer, capture and digital I/O block.
package tcdio_pkg;

  // ****************************************
  // Register map (word index on the plain port)
  // ****************************************
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] REG_CONTROL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_COUNT = 4'h2;
  localparam logic [3:0] REG_LIMIT = 4'h3;
  localparam logic [3:0] REG_CAPTURE = 4'h4;
  localparam logic [3:0] REG_IN_ZERO = 4'h5;
  localparam logic [3:0] REG_IN_ONE = 4'h6;
  localparam logic [3:0] REG_OUT_ZERO = 4'h7;
  localparam logic [3:0] REG_OUT_ONE = 4'h8;
  localparam logic [3:0] REG_OUT_BOTH = 4'h9;

  // ****************************************
  // Control word fields
  // ****************************************
  localparam int unsigned CTL_TASK_LSB = 0;
  localparam int unsigned CTL_EN_BIT = 3;
  localparam int unsigned CTL_CS_BIT = 4;
  localparam int unsigned CTL_PRE_LSB = 5;
  localparam int unsigned CTL_MODE_LSB = 7;
  localparam int unsigned CTL_W = 9;
  localparam logic [8:0] CTL_RESET = 9'h000;

  // ****************************************
  // Status bits and reset values
  // ****************************************
  localparam int unsigned ST_EVENT_BIT = 0;
  localparam int unsigned ST_WRAP_BIT = 1;
  localparam logic [15:0] LIMIT_RESET = 16'hffff;
  localparam logic [15:0] WORD_ZERO = 16'h0000;

  // ****************************************
  // Prescale divisors as log4: 1, 4, 16, 64.
  // ****************************************
  localparam int unsigned PRE_MAX = 64;
  localparam logic [1:0] MODE_FREE = 2'h0;
  localparam logic [1:0] MODE_RISE = 2'h1;
  localparam logic [1:0] MODE_FALL = 2'h2;

  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] prescale;
    logic ext_clk;
    logic enable;
    logic [2:0] task_sel;
  } tcdio_ctl_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } tcdio_bus_type;

endpackage

// [logic/tcdio_in_sync.sv]
// Two-stage synchroniser with edge detection for one digital input.
module tcdio_in_sync (
  input wire logic sys_clk_in,  // Module clock.
  input wire logic rstn_in,     // Asynchronous reset, active low.
  input wire logic pin_in,      // Raw pin level.
  output logic level_out,       // Synchronised level.
  output logic rise_out,        // One-cycle pulse on rising edge.
  output logic fall_out         // One-cycle pulse on falling edge.
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } tcdio_sync_type;

  tcdio_sync_type st_r;
  tcdio_sync_type st_nxt;

  always_comb begin
    st_nxt.meta = pin_in;
    st_nxt.sync = st_r.meta;
    st_nxt.prev = st_r.sync;
  end

  // The first stage feeds only the second one.
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level_out = st_r.sync;
  assign rise_out = st_r.sync & ~st_r.prev;
  assign fall_out = ~st_r.sync & st_r.prev;

endmodule

// [logic/tcdio_top.sv]
// Top of the 16-bit timer with capture, wrap limit and two digital inputs and outputs.
//
// Function
// - Event flag bit0; auto-clear or read-clear
// - Wrap flag bit1 set on wrap; read-clear
// - Count readable and writable, write immediate
// - Writable 16-bit wrap limit
// - Capture modes store count in cache
// - Two digital inputs, two digital outputs
// - Input reads 0 low, 1 high
// - Output control 0 low, 1 high
// - Combined output register, consistent with singles
// - Clock source select; prescale 1/4/16/64 on internal clock only
// - Free mode: count, event on wrap
// - Capture on rise/fall; wrap no event
// - Enable bit starts and stops timer
module tcdio_top #(
  parameter int unsigned COUNT_W = 16  // Counter width.
) (
  input wire logic sys_clk_in,                         // Module clock, 20 MHz.
  input wire logic rstn_in,                            // Asynchronous reset, active low.
  input wire logic [tcdio_pkg::ADDR_W-1:0] addr_in,    // Register index.
  input wire logic [15:0] wdata_in,                    // Write data.
  input wire logic wr_in,                              // Write strobe.
  input wire logic rd_in,                              // Read strobe.
  output logic [15:0] rdata_out,                       // Read data, cycle after strobe.
  input wire logic digital_input_zero_in,              // Input pin 0, capture source.
  input wire logic digital_input_one_in,               // Input pin 1, external clock.
  output logic [1:0] dout_out,                         // Output pins 0 and 1.
  output logic timer_event_out                         // Event flag level for task scheduling.
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (COUNT_W != 16) begin : g_bad_width
    $error("Counter width must be 16");
  end
  // The six-bit prescaler serves division by 64 at most.
  if (tcdio_pkg::PRE_MAX != 64) begin : g_bad_prescale
    $error("Prescaler cannot serve this division");
  end
  if (tcdio_pkg::CTL_W != $bits(tcdio_pkg::tcdio_ctl_type)) begin : g_bad_ctl_width
    $error("Control word width does not match its fields");
  end
  // A word with one bit set must land in the field that the register map gives that bit.
  localparam tcdio_pkg::tcdio_ctl_type CTL_PROBE_EN =
    tcdio_pkg::tcdio_ctl_type'(9'h001 << tcdio_pkg::CTL_EN_BIT);
  localparam tcdio_pkg::tcdio_ctl_type CTL_PROBE_MODE =
    tcdio_pkg::tcdio_ctl_type'(9'h001 << tcdio_pkg::CTL_MODE_LSB);
  if (CTL_PROBE_EN.enable != 1'b1 || CTL_PROBE_MODE.mode != 2'h1) begin : g_bad_ctl_layout
    $error("Control word fields are out of place");
  end

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    tcdio_pkg::tcdio_ctl_type ctl;
    logic [COUNT_W-1:0] count;
    logic [COUNT_W-1:0] limit;
    logic [COUNT_W-1:0] capture;
    logic timer_event_flag;
    logic wrap_flag;
    logic [5:0] pre_cnt;
    logic [1:0] dout;
    logic [15:0] rdata;
  } tcdio_state_type;

  tcdio_state_type st_r;
  tcdio_state_type st_nxt;

  logic in0_level;
  logic in0_rise;
  logic in0_fall;
  logic in1_level;
  logic in1_rise;
  logic tick;
  logic wrap;
  logic capture_hit;
  logic status_read;

  // ****************************************
  // Input synchronisers
  // ****************************************
  tcdio_in_sync u_sync0 (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .pin_in(digital_input_zero_in),
    .level_out(in0_level),
    .rise_out(in0_rise),
    .fall_out(in0_fall)
  );

  tcdio_in_sync u_sync1 (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .pin_in(digital_input_one_in),
    .level_out(in1_level),
    .rise_out(in1_rise),
    .fall_out()
  );

  // True when a strobe hits one register index.
  function automatic logic reg_hit(input logic strobe, input logic [tcdio_pkg::ADDR_W-1:0] a,
                                   input logic [tcdio_pkg::ADDR_W-1:0] idx);
    return strobe & (a == idx);
  endfunction

  // Mask of low prescaler bits that must be all ones for a tick.
  function automatic logic [5:0] pre_mask(input logic [1:0] sel);
    logic [5:0] m;
    m = 6'h00;
    case (sel)
      2'h0: m = 6'h00;
      2'h1: m = 6'h03;
      2'h2: m = 6'h0f;
      default: m = 6'h3f;
    endcase
    return m;
  endfunction

  // ****************************************
  // Count tick, wrap and capture
  // ****************************************
  always_comb begin
    if (st_r.ctl.ext_clk) begin
      tick = st_r.ctl.enable & in1_rise;
    end else begin
      tick = st_r.ctl.enable & ((st_r.pre_cnt & pre_mask(st_r.ctl.prescale)) ==
                                pre_mask(st_r.ctl.prescale));
    end
    wrap = tick & (st_r.count == st_r.limit);
    capture_hit = st_r.ctl.enable & (((st_r.ctl.mode == tcdio_pkg::MODE_RISE) & in0_rise) |
                                     ((st_r.ctl.mode == tcdio_pkg::MODE_FALL) & in0_fall));
    status_read = reg_hit(rd_in, addr_in, tcdio_pkg::REG_STATUS);
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    // The prescaler runs freely while enabled, so a new prescale value takes effect within 64 cycles.
    st_nxt.pre_cnt = st_r.ctl.enable ? st_r.pre_cnt + 6'h01 : 6'h00;
    if (tick) begin
      st_nxt.count = wrap ? '0 : st_r.count + 16'h0001;
    end
    if (capture_hit) begin
      st_nxt.capture = st_r.count;
    end

    // Clears first; sets below override so no event is lost.
    if (status_read) begin
      st_nxt.timer_event_flag = 1'b0;
      st_nxt.wrap_flag = 1'b0;
    end
    if (st_r.ctl.task_sel != 3'h0) begin
      st_nxt.timer_event_flag = 1'b0;
    end

    if (wr_in) begin
      case (addr_in)
        tcdio_pkg::REG_CONTROL: st_nxt.ctl = tcdio_pkg::tcdio_ctl_type'(wdata_in[tcdio_pkg::CTL_W-1:0]);
        tcdio_pkg::REG_COUNT: st_nxt.count = wdata_in;
        tcdio_pkg::REG_LIMIT: st_nxt.limit = wdata_in;
        tcdio_pkg::REG_CAPTURE: st_nxt.capture = wdata_in;
        tcdio_pkg::REG_OUT_ZERO: st_nxt.dout[0] = wdata_in[0];
        tcdio_pkg::REG_OUT_ONE: st_nxt.dout[1] = wdata_in[0];
        tcdio_pkg::REG_OUT_BOTH: st_nxt.dout = wdata_in[1:0];
        default: st_nxt.dout = st_r.dout;
      endcase
    end

    if ((wrap & (st_r.ctl.mode == tcdio_pkg::MODE_FREE)) | capture_hit) begin
      st_nxt.timer_event_flag = 1'b1;
    end
    if (wrap) begin
      st_nxt.wrap_flag = 1'b1;
    end

    st_nxt.rdata = tcdio_pkg::WORD_ZERO;
    if (rd_in) begin
      case (addr_in)
        tcdio_pkg::REG_CONTROL: st_nxt.rdata = {7'h00, st_r.ctl};
        tcdio_pkg::REG_STATUS: st_nxt.rdata = {14'h0000, st_r.wrap_flag, st_r.timer_event_flag};
        tcdio_pkg::REG_COUNT: st_nxt.rdata = st_r.count;
        tcdio_pkg::REG_LIMIT: st_nxt.rdata = st_r.limit;
        tcdio_pkg::REG_CAPTURE: st_nxt.rdata = st_r.capture;
        tcdio_pkg::REG_IN_ZERO: st_nxt.rdata = {15'h0000, in0_level};
        tcdio_pkg::REG_IN_ONE: st_nxt.rdata = {15'h0000, in1_level};
        tcdio_pkg::REG_OUT_ZERO: st_nxt.rdata = {15'h0000, st_r.dout[0]};
        tcdio_pkg::REG_OUT_ONE: st_nxt.rdata = {15'h0000, st_r.dout[1]};
        tcdio_pkg::REG_OUT_BOTH: st_nxt.rdata = {14'h0000, st_r.dout};
        default: st_nxt.rdata = tcdio_pkg::WORD_ZERO;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_r <= '0;
      st_r.ctl <= tcdio_pkg::tcdio_ctl_type'(tcdio_pkg::CTL_RESET);
      st_r.limit <= tcdio_pkg::LIMIT_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata_out = st_r.rdata;
  assign dout_out = st_r.dout;
  assign timer_event_out = st_r.timer_event_flag;

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_wrap_free;
    wrap && st_r.ctl.mode == tcdio_pkg::MODE_FREE;
  endsequence

  // A status read in a cycle that raises no new event and no wrap.
  sequence s_quiet_read;
    status_read && !wrap && !capture_hit;
  endsequence

  // A synchronised rising edge on input 1: low in one cycle, high in the next.
  sequence s_ext_edge;
    !in1_level ##1 in1_level;
  endsequence

  sequence s_ext_counting;
    st_r.ctl.enable && st_r.ctl.ext_clk;
  endsequence

  a_count_wraps_zero: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (wrap && !wr_in) |=> st_r.count == 16'h0000)
    else $error("Count did not return to zero after wrap");

  a_count_increments: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (tick && !wrap && !wr_in) |=> st_r.count == $past(st_r.count) + 16'h0001)
    else $error("Count did not increment on tick");

  a_count_held_off: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (!st_r.ctl.enable && !wr_in) |=> st_r.count == $past(st_r.count))
    else $error("Count moved while disabled");

  a_count_write: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (wr_in && addr_in == tcdio_pkg::REG_COUNT) |=> st_r.count == $past(wdata_in))
    else $error("Count write not applied");

  a_wrap_flag_set: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    wrap |=> st_r.wrap_flag)
    else $error("Wrap flag not set");

  a_status_read_clr: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (status_read && !wrap) |=> !st_r.wrap_flag)
    else $error("Wrap flag not cleared by status read");

  a_event_free_wrap: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    s_wrap_free |=> st_r.timer_event_flag)
    else $error("Event flag not set on free-mode wrap");

  a_capture_latch: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (capture_hit && !wr_in) |=> (st_r.capture == $past(st_r.count)) && st_r.timer_event_flag)
    else $error("Capture did not latch count or set event");

  a_output_both: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (wr_in && addr_in == tcdio_pkg::REG_OUT_BOTH) |=> dout_out == $past(wdata_in[1:0]))
    else $error("Combined output write not applied");

  a_event_read_clr: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    s_quiet_read |=> !st_r.timer_event_flag)
    else $error("Event flag not cleared by status read");

  a_event_task_clr: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (st_r.ctl.task_sel != 3'h0 && !wrap && !capture_hit) |=> !st_r.timer_event_flag)
    else $error("Event flag not cleared while a task is selected");

  a_event_hold: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (st_r.timer_event_flag && st_r.ctl.task_sel == 3'h0 && !status_read) |=> st_r.timer_event_flag)
    else $error("Event flag lost without a status read");

  a_wrap_flag_hold: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (st_r.wrap_flag && !status_read) |=> st_r.wrap_flag)
    else $error("Wrap flag lost without a status read");

  a_wrap_no_event: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (wrap && st_r.ctl.mode != tcdio_pkg::MODE_FREE && !capture_hit && !st_r.timer_event_flag)
      |=> !st_r.timer_event_flag)
    else $error("Wrap set the event flag outside free mode");

  a_ext_tick: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (s_ext_edge ##0 s_ext_counting) |-> tick)
    else $error("External edge did not tick the counter");

  a_ext_only: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (st_r.ctl.ext_clk && !in1_rise) |-> !tick)
    else $error("Tick without an external edge");

  a_int_every: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (st_r.ctl.enable && !st_r.ctl.ext_clk && st_r.ctl.prescale == 2'h0) |-> tick)
    else $error("Undivided internal clock missed a tick");

  a_int_tick_gap: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (tick && !st_r.ctl.ext_clk && st_r.ctl.prescale != 2'h0 && !wr_in) |=> !tick)
    else $error("Divided internal clock ticked twice in a row");

  a_no_tick_off: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    !st_r.ctl.enable |-> !tick && !capture_hit)
    else $error("Timer acted while disabled");

  a_limit_write: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    reg_hit(wr_in, addr_in, tcdio_pkg::REG_LIMIT) |=> st_r.limit == $past(wdata_in))
    else $error("Limit write not applied");

  a_capture_still: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    !(capture_hit || reg_hit(wr_in, addr_in, tcdio_pkg::REG_CAPTURE)) |=> st_r.capture == $past(st_r.capture))
    else $error("Capture cache changed without an edge");

  a_out_zero_write: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    reg_hit(wr_in, addr_in, tcdio_pkg::REG_OUT_ZERO) |=> dout_out == {$past(dout_out[1]), $past(wdata_in[0])})
    else $error("Output zero write not applied");

  a_out_one_write: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    reg_hit(wr_in, addr_in, tcdio_pkg::REG_OUT_ONE) |=> dout_out == {$past(wdata_in[0]), $past(dout_out[0])})
    else $error("Output one write not applied");

  a_read_status: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    reg_hit(rd_in, addr_in, tcdio_pkg::REG_STATUS)
      |=> rdata_out == {14'h0000, $past(st_r.wrap_flag), $past(st_r.timer_event_flag)})
    else $error("Status read returned wrong flags");

  a_read_count: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    reg_hit(rd_in, addr_in, tcdio_pkg::REG_COUNT) |=> rdata_out == $past(st_r.count))
    else $error("Count read returned wrong value");

  a_read_capture: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    reg_hit(rd_in, addr_in, tcdio_pkg::REG_CAPTURE) |=> rdata_out == $past(st_r.capture))
    else $error("Capture read returned wrong value");

  a_read_both: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    reg_hit(rd_in, addr_in, tcdio_pkg::REG_OUT_BOTH) |=> rdata_out == {14'h0000, $past(dout_out)})
    else $error("Combined output read disagrees with pins");

  a_sync_zero: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    $past(rstn_in, 2) |-> in0_level == $past(digital_input_zero_in, 2))
    else $error("Input zero not delayed by two flops");

  a_sync_one: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    $past(rstn_in, 2) |-> in1_level == $past(digital_input_one_in, 2))
    else $error("Input one not delayed by two flops");

endmodule

// [tb/tb_timer_capture_and_digital_io.sv]
// Self-checking testbench of the timer, capture and digital I/O block.
module tb_timer_capture_and_digital_io;
  timeunit 1ns;
  timeprecision 1ns;

  logic sys_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [3:0] addr_in = 4'h0;
  logic [15:0] wdata_in = 16'h0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [15:0] rdata_out;
  logic din0;
  logic din1;
  logic [1:0] dout_out;
  logic timer_event_out;
  logic [15:0] c;
  int n_fail = 0;
  int n_tests = 0;

  always #25 sys_clk_in = ~sys_clk_in;

  tcdio_top dut (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .digital_input_zero_in(din0),
    .digital_input_one_in(din1), .dout_out(dout_out), .timer_event_out(timer_event_out));

  tcdio_pins_model pins (.clk_in(sys_clk_in), .din_zero_out(din0), .din_one_out(din1));

  // ****************************************
  // Bus tasks and comparison
  // ****************************************
  function automatic logic [15:0] ctl(input logic [1:0] m, input logic [1:0] p, input logic x, input logic e,
    input logic [2:0] t);
    return {7'h00, m, p, x, e, t};
  endfunction

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge sys_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    #1;
    d = rdata_out;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rc(input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd(a, d);
    chk(d, exp);
  endtask

  task automatic report_and_stop();
    if (n_fail == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ****************************************
  // Watchdog
  // ****************************************
  // The tests need about 1300 cycles; a hang is cut off well beyond that.
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    n_fail++;
    report_and_stop();
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (8) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    rc(tcdio_pkg::REG_LIMIT, 16'hffff);
    rc(tcdio_pkg::REG_STATUS, 16'h0000);
    rc(4'hf, 16'h0000);
    wr(tcdio_pkg::REG_OUT_ZERO, 16'h0001);
    rc(tcdio_pkg::REG_OUT_BOTH, 16'h0001);
    chk({14'h0000, dout_out}, 16'h0001);
    wr(tcdio_pkg::REG_OUT_BOTH, 16'h0002);
    rc(tcdio_pkg::REG_OUT_ZERO, 16'h0000);
    rc(tcdio_pkg::REG_OUT_ONE, 16'h0001);
    chk({14'h0000, dout_out}, 16'h0002);
    wr(tcdio_pkg::REG_OUT_ONE, 16'h0000);
    rc(tcdio_pkg::REG_OUT_BOTH, 16'h0000);
    chk({14'h0000, dout_out}, 16'h0000);
    pins.set_levels(1'b1, 1'b1);
    rc(tcdio_pkg::REG_IN_ZERO, 16'h0001);
    rc(tcdio_pkg::REG_IN_ONE, 16'h0001);
    pins.set_levels(1'b0, 1'b0);
    rc(tcdio_pkg::REG_IN_ZERO, 16'h0000);
    rc(tcdio_pkg::REG_IN_ONE, 16'h0000);
    wr(tcdio_pkg::REG_LIMIT, 16'h0003);
    rc(tcdio_pkg::REG_LIMIT, 16'h0003);
    wr(tcdio_pkg::REG_COUNT, 16'h0000);
    wr(tcdio_pkg::REG_CONTROL, ctl(tcdio_pkg::MODE_FREE, 2'h3, 1'b1, 1'b1, 3'h0));
    rc(tcdio_pkg::REG_CONTROL, ctl(tcdio_pkg::MODE_FREE, 2'h3, 1'b1, 1'b1, 3'h0));
    pins.pulse(5);
    chk({15'h0000, timer_event_out}, 16'h0001);
    rc(tcdio_pkg::REG_COUNT, 16'h0001);
    rc(tcdio_pkg::REG_STATUS, 16'h0003);
    rc(tcdio_pkg::REG_STATUS, 16'h0000);
    for (int t = 1; t <= 4; t++) begin
      wr(tcdio_pkg::REG_COUNT, 16'h0003);
      wr(tcdio_pkg::REG_CONTROL, ctl(tcdio_pkg::MODE_FREE, 2'h0, 1'b1, 1'b1, t[2:0]));
      pins.pulse(1);
      rc(tcdio_pkg::REG_STATUS, 16'h0002);
    end
    for (int i = 0; i < 2; i++) begin
      wr(tcdio_pkg::REG_CONTROL, ctl(i == 0 ? tcdio_pkg::MODE_RISE : tcdio_pkg::MODE_FALL, 2'h0, 1'b1, 1'b1, 3'h0));
      wr(tcdio_pkg::REG_COUNT, 16'h0007 + 16'(2 * i));
      pins.set_levels(i == 0, 1'b0);
      rc(tcdio_pkg::REG_CAPTURE, 16'h0007 + 16'(2 * i));
      rc(tcdio_pkg::REG_STATUS, 16'h0001);
      wr(tcdio_pkg::REG_COUNT, 16'h0003);
      pins.pulse(1);
      rc(tcdio_pkg::REG_STATUS, 16'h0002);
    end
    wr(tcdio_pkg::REG_CAPTURE, 16'h1234);
    rc(tcdio_pkg::REG_CAPTURE, 16'h1234);
    wr(tcdio_pkg::REG_CONTROL, ctl(2'h3, 2'h0, 1'b1, 1'b1, 3'h0));
    wr(tcdio_pkg::REG_COUNT, 16'h0003);
    pins.pulse(1);
    rc(tcdio_pkg::REG_STATUS, 16'h0002);
    wr(tcdio_pkg::REG_CONTROL, ctl(tcdio_pkg::MODE_FREE, 2'h0, 1'b1, 1'b0, 3'h0));
    wr(tcdio_pkg::REG_COUNT, 16'h0002);
    pins.pulse(2);
    rc(tcdio_pkg::REG_COUNT, 16'h0002);
    wr(tcdio_pkg::REG_LIMIT, 16'hffff);
    // The disable write keeps the timer enabled for two more cycles, and the enable write adds none, hence the small tolerance.
    for (int p = 0; p < 4; p++) begin
      wr(tcdio_pkg::REG_COUNT, 16'h0000);
      wr(tcdio_pkg::REG_CONTROL, ctl(tcdio_pkg::MODE_FREE, p[1:0], 1'b0, 1'b1, 3'h0));
      repeat (256) @(posedge sys_clk_in);
      wr(tcdio_pkg::REG_CONTROL, 16'h0000);
      rd(tcdio_pkg::REG_COUNT, c);
      n_tests++;
      if (c < (16'(256 >> (2 * p)) - 16'h0002) || c > (16'(256 >> (2 * p)) + 16'h0002)) begin
        n_fail++;
        $display("wrong value at %0t: internal count %h", $time, c);
      end
    end
    report_and_stop();
  end
endmodule

// [tb/tcdio_pins_model.sv]
// Model of the external pins that feed the two digital inputs.
module tcdio_pins_model (
  input wire logic clk_in,  // Module clock.
  output logic din_zero_out,  // Digital input 0 pin.
  output logic din_one_out  // Digital input 1 pin.
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    din_zero_out = 1'b0;
    din_one_out = 1'b0;
  end

  // Levels settle for five cycles so the synchroniser and edge detect have landed before any read.
  task automatic set_levels(input logic z, input logic o);
    @(posedge clk_in);
    din_zero_out <= z;
    din_one_out <= o;
    repeat (5) @(posedge clk_in);
  endtask

  // The high half of a pulse lasts three cycles and the low half at least four, so a two-flop synchroniser cannot miss it.
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk_in);
      din_one_out <= 1'b1;
      repeat (3) @(posedge clk_in);
      din_one_out <= 1'b0;
      repeat (3) @(posedge clk_in);
    end
    repeat (4) @(posedge clk_in);
  endtask
endmodule
